// ===== dv/dsi3_crm_command_exec_tb_top.sv
// self-checking bench for the command executor
`timescale 1ns/1ns
module dsi3_crm_command_exec_tb_top;
  typedef struct packed {
    logic [23:0] m;
    logic r;
    logic [3:0] ra;
    logic [15:0] rd;
  } row_t;
  localparam row_t ROWS [15] = '{
    {24'h080003, 1'b1, 4'h3, 16'h0003},
    {24'h080005, 1'b0, 4'h0, 16'h0000},
    {24'h3806a5, 1'b1, 4'h3, 16'h00a5},
    {24'h38075a, 1'b1, 4'h3, 16'h5aa5},
    {24'h300600, 1'b1, 4'h3, 16'h5aa5},
    {24'h000600, 1'b0, 4'h0, 16'h0000},
    {24'h400600, 1'b0, 4'h0, 16'h0000},
    {24'h3803c3, 1'b1, 4'h3, 16'hc300},
    {24'h3802ff, 1'b1, 4'h3, 16'hc300},
    {24'h380577, 1'b1, 4'h3, 16'h0000},
    {24'h380411, 1'b1, 4'h3, 16'h0011},
    {24'h382099, 1'b1, 4'h3, 16'h0000},
    {24'h302000, 1'b1, 4'h3, 16'h0000},
    {24'h280699, 1'b0, 4'h0, 16'h0000},
    {24'h5b0000, 1'b0, 4'h0, 16'h0000}
  };
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic cmdValid;
  logic [31:0] cmdWord;
  // byte 2 read-only, byte 5 unreadable
  logic [15:0] regReadable = 16'hffdf;
  logic [15:0] regWritable = 16'hfffb;
  logic [15:0] regLockable = 16'h0010;
  logic [3:0] chipDurationSetting = 4'h9;
  logic bgDiagEnable = 1'b0;
  logic respValid, initDoneLock, periodicMode, cmdRespMode;
  logic bgDiagActive, userArrayVerify, crcError;
  logic [31:0] respWord;
  logic [3:0] nodeAddress;
  int failures = 0;
  int checks_done = 0;
  always #5 core_clk = ~core_clk;
  dsi3_master_model u_master (
    .core_clk(core_clk),
    .cmdValid(cmdValid),
    .cmdWord(cmdWord)
  );
  crm_command_exec #(.NUM_REGS(16)) u_dut (
    .core_clk(core_clk),
    .srst(srst),
    .cmdValid(cmdValid),
    .cmdWord(cmdWord),
    .regReadable(regReadable),
    .regWritable(regWritable),
    .regLockable(regLockable),
    .chipDurationSetting(chipDurationSetting),
    .bgDiagEnable(bgDiagEnable),
    .respValid(respValid),
    .respWord(respWord),
    .nodeAddress(nodeAddress),
    .initDoneLock(initDoneLock),
    .periodicMode(periodicMode),
    .cmdRespMode(cmdRespMode),
    .bgDiagActive(bgDiagActive),
    .userArrayVerify(userArrayVerify),
    .crcError(crcError)
  );
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // six cycles cover the three-cycle answer with margin
  task automatic xfer(input row_t t, input logic bad);
    logic [31:0] w;
    logic [23:0] e;
    int nr;
    int ne;
    nr = 0;
    ne = 0;
    w = 32'h0;
    e = {t.ra, t.m[19:16], t.rd};
    u_master.send(t.m, bad);
    repeat (6) begin
      @(negedge core_clk);
      if (respValid === 1'b1) begin
        nr++;
        w = respWord;
      end
      if (crcError === 1'b1) ne++;
    end
    chk("respCount", {31'h0, t.r}, 32'(nr));
    chk("crcErrorCount", {31'h0, bad}, 32'(ne));
    if (t.r) chk("respWord", {e, u_master.crc8(e)}, w);
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    chk("crmOn", 32'h1, {31'h0, cmdRespMode});
    foreach (ROWS[i]) xfer(ROWS[i], 1'b0);
    for (int c = 1; c < 16; c++) begin
      if (c != 8 && c != 11)
        xfer({4'h3, 4'(c), 16'h1234, 1'b1, 4'h3, 16'h0}, 1'b0);
    end
    xfer({24'h300600, 1'b0, 4'h3, 16'h0}, 1'b1);
    xfer({24'h3b0000, 1'b1, 4'h3, 16'h0900}, 1'b0);
    chk("modes", 32'h1a, {27'h0, initDoneLock, periodicMode, cmdRespMode,
      userArrayVerify, bgDiagActive});
    @(posedge core_clk);
    bgDiagEnable <= 1'b1;
    repeat (2) @(negedge core_clk);
    chk("bgDiag", 32'h1, {31'h0, bgDiagActive});
    xfer({24'h300600, 1'b0, 4'h3, 16'h0}, 1'b0);
    @(posedge core_clk);
    srst <= 1'b1;
    @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    chk("afterReset", 32'h40, {23'h0, initDoneLock, periodicMode,
      cmdRespMode, userArrayVerify, bgDiagActive, nodeAddress});
    xfer({24'h0b0000, 1'b0, 4'h0, 16'h0}, 1'b0);
    chk("globalLock", 32'h1, {31'h0, initDoneLock});
    print_verdict();
  end
  // whole run is a few hundred cycles
  initial begin
    #100000;
    failures++;
    print_verdict();
  end
endmodule // dsi3_crm_command_exec_tb_top

// ===== dv/dsi3_master_model.sv
// bus master model that frames commands with their crc
`timescale 1ns/1ns
module dsi3_master_model (
  input wire logic core_clk,
  output logic cmdValid,
  output logic [31:0] cmdWord
);
  // augmented crc: message, then eight zeros, seeded all ones
  function automatic logic [7:0] crc8(input logic [23:0] m);
    logic [7:0] r;
    logic [31:0] s;
    r = 8'hff;
    s = {m, 8'h00};
    for (int i = 31; i >= 0; i--) begin
      r = r[7] ? ({r[6:0], s[i]} ^ 8'h2f) : {r[6:0], s[i]};
    end
    return r;
  endfunction
  initial begin
    cmdValid = 1'b0;
    cmdWord = 32'h0;
  end
  // a corrupted crc goes out only when the caller asks for it
  task automatic send(input logic [23:0] m, input logic bad);
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdWord <= {m, crc8(m) ^ {7'h0, bad}};
    @(posedge core_clk);
    cmdValid <= 1'b0;
    // released word shows no stale value
    cmdWord <= ~{m, crc8(m)};
  endtask
endmodule // dsi3_master_model

// ===== logic/crc8_serial.sv
// serial crc8 over a 32-bit word, msb first, seeded ones
`timescale 1ns/1ns
module crc8_serial (
  input wire logic [31:0] word,
  output logic [7:0] remainder
);
  always_comb begin
    logic [7:0] sr;
    logic fb;
    sr = crc_exec_seed();
    fb = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      fb = sr[7];
      sr = {sr[6:0], word[i]};
      if (fb) begin
        sr = sr ^ crm_exec_pkg::CRC_POLY;
      end
    end
    remainder = sr;
  end

  function automatic logic [7:0] crc_exec_seed();
    return crm_exec_pkg::CRC_SEED;
  endfunction
endmodule // crc8_serial

// ===== logic/crm_command_exec.sv
// command executor for command and response mode
`timescale 1ns/1ns
module crm_command_exec #(
  parameter int NUM_REGS = 64
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic cmdValid,
  input wire logic [31:0] cmdWord,
  input wire logic [NUM_REGS-1:0] regReadable,
  input wire logic [NUM_REGS-1:0] regWritable,
  input wire logic [NUM_REGS-1:0] regLockable,
  input wire logic [3:0] chipDurationSetting,
  input wire logic bgDiagEnable,
  output logic respValid,
  output logic [31:0] respWord,
  output logic [3:0] nodeAddress,
  output logic initDoneLock,
  output logic periodicMode,
  output logic cmdRespMode,
  output logic bgDiagActive,
  output logic userArrayVerify,
  output logic crcError
);
  localparam int AW = $clog2(NUM_REGS);
  localparam int CHIP_POS = crm_exec_pkg::CHIP_LSB;

  logic [7:0] regFile_r [NUM_REGS];
  logic [3:0] nodeAddr_r;
  logic lock_r;
  crm_exec_pkg::exec_state_t state_r;
  logic [31:0] cmd_r;
  logic [7:0] crcRem;
  logic [31:0] respWord_r;
  logic respValid_r;
  logic crcError_r;

  crc8_serial u_check (
    .word(cmd_r),
    .remainder(crcRem)
  );

  // response crc: message with a zero byte gives the remainder to send
  logic [7:0] respCrc;
  logic [31:0] respBody_nxt;
  crc8_serial u_gen (
    .word({respBody_nxt[31:8], 8'h00}),
    .remainder(respCrc)
  );

  logic [3:0] fAddr;
  logic [3:0] fCmd;
  logic [7:0] fRegAddr;
  logic [7:0] fData;
  logic addrMatch;
  logic isGlobal;
  logic [7:0] evenIdx;
  logic inMap;
  logic canWrite;
  logic doWrite;
  logic doAnswer;
  logic doPeriodic;

  assign fAddr = cmd_r[31:28];
  assign fCmd = cmd_r[27:24];
  assign fRegAddr = cmd_r[23:16];
  assign fData = cmd_r[15:8];
  assign addrMatch = (fAddr == nodeAddr_r);
  assign isGlobal = (fAddr == crm_exec_pkg::GLOBAL_ADDR);
  assign evenIdx = {fRegAddr[7:1], 1'b0};
  assign inMap = ({1'b0, fRegAddr} < 9'(NUM_REGS));

  // write permission also honours the init-done lock
  assign canWrite = inMap && regWritable[fRegAddr[AW-1:0]] &&
    !(lock_r && regLockable[fRegAddr[AW-1:0]]);

  always_comb begin
    doWrite = 1'b0;
    doAnswer = 1'b0;
    doPeriodic = 1'b0;
    if (!lock_r) begin
      unique case (fCmd)
        crm_exec_pkg::CMD_READ: begin
          doAnswer = addrMatch && !isGlobal;
        end
        crm_exec_pkg::CMD_WRITE: begin
          if (addrMatch && !isGlobal) begin
            doAnswer = 1'b1;
            doWrite = canWrite;
          end else if (isGlobal && nodeAddr_r == crm_exec_pkg::GLOBAL_ADDR
              && fRegAddr == crm_exec_pkg::NODE_ADDR_REG) begin
            doAnswer = 1'b1;
            doWrite = canWrite;
          end
        end
        crm_exec_pkg::CMD_PERIODIC: begin
          if (isGlobal) begin
            doPeriodic = 1'b1;
          end else if (addrMatch) begin
            doPeriodic = 1'b1;
            doAnswer = 1'b1;
          end
        end
        default: begin
          doAnswer = addrMatch && !isGlobal;
        end
      endcase
    end
  end

  function automatic logic [7:0] readByte(input logic [7:0] a,
      input logic [7:0] wa, input logic [7:0] wd, input logic we);
    logic [7:0] v;
    v = 8'h00;
    if ({1'b0, a} < 9'(NUM_REGS) && regReadable[a[AW-1:0]]) begin
      v = regFile_r[a[AW-1:0]];
      if (we && a == wa) begin
        v = wd;
      end
    end
    return v;
  endfunction

  // answer assembled from post-write contents of the even/odd pair
  always_comb begin
    logic [7:0] lo;
    logic [7:0] hi;
    logic [3:0] echoAddr;
    lo = readByte(evenIdx, fRegAddr, fData, doWrite);
    hi = readByte(evenIdx + 8'h01, fRegAddr, fData, doWrite);
    echoAddr = nodeAddr_r;
    if (fCmd == crm_exec_pkg::CMD_WRITE && doWrite &&
        fRegAddr == crm_exec_pkg::NODE_ADDR_REG) begin
      echoAddr = fData[3:0];
    end
    respBody_nxt = {echoAddr, fCmd, hi, lo, 8'h00};
    if (fCmd == crm_exec_pkg::CMD_PERIODIC) begin
      respBody_nxt[23:16] = 8'h00;
      respBody_nxt[15:8] = 8'h00;
      respBody_nxt[CHIP_POS+8 +: 4] = chipDurationSetting;
    end else if (fCmd != crm_exec_pkg::CMD_READ &&
        fCmd != crm_exec_pkg::CMD_WRITE) begin
      respBody_nxt[23:8] = 16'h0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= crm_exec_pkg::ST_IDLE;
      cmd_r <= 32'h0000_0000;
    end else begin
      unique case (state_r)
        crm_exec_pkg::ST_IDLE: begin
          if (cmdValid) begin
            cmd_r <= cmdWord;
            state_r <= crm_exec_pkg::ST_CHECK;
          end
        end
        crm_exec_pkg::ST_CHECK: begin
          if (crcRem == 8'h00) begin
            state_r <= crm_exec_pkg::ST_EXEC;
          end else begin
            state_r <= crm_exec_pkg::ST_IDLE;
          end
        end
        crm_exec_pkg::ST_EXEC: begin
          state_r <= crm_exec_pkg::ST_ANSWER;
        end
        crm_exec_pkg::ST_ANSWER: begin
          state_r <= crm_exec_pkg::ST_IDLE;
        end
      endcase
    end
  end

  logic execNow;
  assign execNow = (state_r == crm_exec_pkg::ST_EXEC);

  // register file; a write executes in the same cycle its answer is built
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regFile_r[i] <= crm_exec_pkg::REG_RST;
      end
    end else if (execNow && doWrite) begin
      regFile_r[fRegAddr[AW-1:0]] <= fData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      nodeAddr_r <= crm_exec_pkg::NODE_ADDR_RST;
    end else if (execNow && doWrite &&
        fRegAddr == crm_exec_pkg::NODE_ADDR_REG) begin
      nodeAddr_r <= fData[3:0];
    end
  end

  // lock is sticky until reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lock_r <= 1'b0;
    end else if (execNow && doPeriodic) begin
      lock_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      respValid_r <= 1'b0;
      respWord_r <= 32'h0000_0000;
    end else begin
      respValid_r <= execNow && doAnswer;
      if (execNow && doAnswer) begin
        respWord_r <= {respBody_nxt[31:8], respCrc};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      crcError_r <= 1'b0;
    end else begin
      crcError_r <= (state_r == crm_exec_pkg::ST_CHECK) &&
        (crcRem != 8'h00);
    end
  end

  assign respValid = respValid_r;
  assign respWord = respWord_r;
  assign nodeAddress = nodeAddr_r;
  assign initDoneLock = lock_r;
  assign periodicMode = lock_r;
  assign cmdRespMode = !lock_r;
  assign bgDiagActive = lock_r && bgDiagEnable;
  assign userArrayVerify = lock_r;
  assign crcError = crcError_r;

  a_bad_crc_silent: assert property (@(posedge core_clk) disable iff (srst)
    (state_r == crm_exec_pkg::ST_CHECK && crcRem != 8'h00) |->
    ##[1:3] !respValid) else $error("answer after bad crc");
  a_lock_sticky: assert property (@(posedge core_clk) disable iff (srst)
    $rose(lock_r) |-> lock_r [*8]) else $error("lock dropped");
  a_lock_cause: assert property (@(posedge core_clk) disable iff (srst)
    $rose(lock_r) |-> $past(execNow && fCmd == crm_exec_pkg::CMD_PERIODIC))
    else $error("lock without periodic entry");
  a_global_read_drop: assert property (@(posedge core_clk) disable iff (srst)
    (execNow && isGlobal && fCmd == crm_exec_pkg::CMD_READ) |=> !respValid)
    else $error("global read answered");
  a_global_periodic_collection_mode: assert property (@(posedge core_clk) disable iff (srst)
    (execNow && !lock_r && isGlobal && fCmd == crm_exec_pkg::CMD_PERIODIC)
    |=> !respValid && lock_r) else $error("global periodic wrong");
  a_match_periodic_collection_mode: assert property (@(posedge core_clk) disable iff (srst)
    (execNow && !lock_r && !isGlobal && addrMatch &&
    fCmd == crm_exec_pkg::CMD_PERIODIC) |=> respValid &&
    respWord[19:16] == $past(chipDurationSetting) &&
    respWord[23:20] == 4'h0) else $error("periodic answer wrong");
  a_read_echo: assert property (@(posedge core_clk) disable iff (srst)
    (execNow && doAnswer && fCmd == crm_exec_pkg::CMD_READ) |=>
    respWord[31:24] == {$past(nodeAddr_r), crm_exec_pkg::CMD_READ})
    else $error("read echo wrong");
  a_one_answer: assert property (@(posedge core_clk) disable iff (srst)
    respValid |=> !respValid) else $error("double answer");
  a_global_write: assert property (@(posedge core_clk) disable iff (srst)
    (execNow && isGlobal && fCmd == crm_exec_pkg::CMD_WRITE &&
    nodeAddr_r != crm_exec_pkg::GLOBAL_ADDR) |=> !respValid)
    else $error("global write answered");
endmodule // crm_command_exec

// ===== pkg/crm_exec_pkg.sv
// constants and types for the command and response mode executor
package crm_exec_pkg;
  localparam logic [3:0] GLOBAL_ADDR = 4'h0;
  localparam logic [3:0] CMD_READ = 4'h0;
  localparam logic [3:0] CMD_WRITE = 4'h8;
  localparam logic [3:0] CMD_PERIODIC = 4'hb;
  localparam logic [7:0] CRC_SEED = 8'hff;
  localparam logic [7:0] CRC_POLY = 8'h2f;
  localparam logic [7:0] NODE_ADDR_REG = 8'h00;
  localparam int CHIP_LSB = 8;
  localparam logic [3:0] NODE_ADDR_RST = 4'h0;
  localparam logic [7:0] REG_RST = 8'h00;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_EXEC = 2'b10,
    ST_ANSWER = 2'b11
  } exec_state_t;
endpackage
